// ---- shared/bir_defs.svh ----
`ifndef BIR_DEFS_SVH
`define BIR_DEFS_SVH
`define BIR_WIDTH_10 10
`define BIR_WIDTH_9 9
`define BIR_WIDTH_8 8
`define BIR_OE_COUNT 3
`define BIR_OE_ALL_ON 3'h0
`define BIR_Q_RESET 1'b0
`define BIR_CLK_PREV_RESET 1'b1
`define BIR_EN_GLITCH_NS 3
`define BIR_CLK_PERIOD_NS 10
`endif

// ---- shared/bir_pkg.sv ----
package bir_pkg;
	typedef enum logic [1:0]
	{
		BIR_POL_TRUE = 2'h1,
		BIR_POL_INV = 2'h2
	} bir_polarity_t;
endpackage

// ---- verilog/bir_top.sv ----
// Notes on behaviour
// - Each stored bit is an edge-triggered flop on one common register clock.
// - Ten-bit variant: buffered outputs, no clock enable, no clear.
// - Nine-bit variant adds common active-low clock enable and clear.
// - Eight-bit variant adds three active-low output-drive enables.
// - Data is captured on the rising transition of the register clock.
// - Enable low: each data bit is stored at the rising register clock.
// - Enable high: stored bits hold whatever data or clock do.
// - Clear acts asynchronously and is common to all bits.
// - Clear low forces stored bits low; driven outputs show cleared value.
// - New data enters storage only while clear is high.
// - Output control high puts every bus output in high impedance.
// - Output control low drives the stored value onto the bus.
// - Polarity parameter selects true or inverted outputs only.
`timescale 1ns/10ps
`include "bir_defs.svh"
module bir_top
	import bir_pkg::*;
#(
	parameter int WIDTH = `BIR_WIDTH_10,
	parameter bir_polarity_t POLARITY = BIR_POL_TRUE
)
(
	input wire logic SYS_CLK_IN,
	input wire logic NRST_IN,
	input wire logic CLK_EN_IN,
	input wire logic REG_CLOCK_IN,
	input wire logic ENABLE_N_IN,
	input wire logic CLEAR_N_IN,
	input wire logic [`BIR_OE_COUNT-1:0] OE_N_IN,
	input wire logic [WIDTH-1:0] D_IN,
	output logic [WIDTH-1:0] Y_OUT,
	output logic [WIDTH-1:0] Y_OE_OUT
);
	localparam bit HAS_CTRL = (WIDTH != `BIR_WIDTH_10);
	localparam bit HAS_MULTI_OE = (WIDTH == `BIR_WIDTH_8);
	localparam bit INV = (POLARITY == BIR_POL_INV);
	localparam logic [WIDTH-1:0] Q_RESET = {WIDTH{`BIR_Q_RESET}};
	localparam logic [WIDTH-1:0] Y_RESET = {WIDTH{INV ^ `BIR_Q_RESET}};

	logic clear_n;
	logic enable_n;
	logic drive;
	logic clk_rise;
	logic load;
	logic reg_clock_prev;
	logic next_reg_clock_prev;
	logic [WIDTH-1:0] q;
	logic [WIDTH-1:0] y;
	logic [WIDTH-1:0] next_q;
	logic [WIDTH-1:0] next_y;

	// Ten-bit variant has no enable or clear pins in use
	assign clear_n = HAS_CTRL ? CLEAR_N_IN : 1'b1;
	assign enable_n = HAS_CTRL ? ENABLE_N_IN : 1'b0;

	// Eight-bit: all three must be low before the bus is taken; other widths use bit 0 only
	always_comb
	begin
		if (HAS_MULTI_OE)
		begin
			drive = (OE_N_IN == `BIR_OE_ALL_ON);
		end
		else
		begin
			drive = !OE_N_IN[0];
		end
	end

	// Clear does not touch the drive path
	assign Y_OE_OUT = {WIDTH{drive}};
	assign Y_OUT = y;

	// Edge detector on the sampled register clock
	always_comb
	begin
		if (CLK_EN_IN)
		begin
			next_reg_clock_prev = REG_CLOCK_IN;
		end
		else
		begin
			next_reg_clock_prev = reg_clock_prev;
		end
	end

	// Reset high so a clock already high at release is no edge
	always_ff @(posedge SYS_CLK_IN or negedge NRST_IN)
	begin
		if (!NRST_IN)
		begin
			reg_clock_prev <= `BIR_CLK_PREV_RESET;
		end
		else
		begin
			reg_clock_prev <= next_reg_clock_prev;
		end
	end

	assign clk_rise = REG_CLOCK_IN && !reg_clock_prev;

	// Enable is sampled once per cycle; spikes shorter than that are lost
	always_comb
	begin
		load = CLK_EN_IN && clk_rise && !enable_n && clear_n;
	end

	genvar i;
	generate
		for (i = 0; i < WIDTH; i = i + 1)
		begin : g_bit
			assign next_q[i] = load ? D_IN[i] : q[i];
			assign next_y[i] = INV ? !next_q[i] : next_q[i];
		end
	endgenerate

	// Output value is kept in its own flops to give a clean data output
	always_ff @(posedge SYS_CLK_IN or negedge NRST_IN or negedge clear_n)
	begin
		if (!NRST_IN || !clear_n)
		begin
			q <= Q_RESET;
			y <= Y_RESET;
		end
		else
		begin
			q <= next_q;
			y <= next_y;
		end
	end

	sequence s_load;
		CLK_EN_IN && clk_rise && !enable_n && clear_n;
	endsequence

	sequence s_hold_enable;
		CLK_EN_IN && enable_n && clear_n;
	endsequence

	sequence s_frozen;
		!CLK_EN_IN && clear_n;
	endsequence

	sequence s_no_edge3;
		(CLK_EN_IN && !clk_rise && clear_n) [*3];
	endsequence

	sequence s_still_set;
		clear_n;
	endsequence

	sequence s_idle;
		CLK_EN_IN && !clk_rise && clear_n;
	endsequence

	load_capture_a: assert property (
		@(posedge SYS_CLK_IN) disable iff (!NRST_IN)
		s_load ##1 s_still_set |-> q == $past(D_IN)
	)
	else
		$error("register did not capture data on clock rise");

	enable_hold_a: assert property (
		@(posedge SYS_CLK_IN) disable iff (!NRST_IN)
		s_hold_enable ##1 s_still_set |-> $stable(q)
	)
	else
		$error("stored word changed while enable was high");

	freeze_hold_a: assert property (
		@(posedge SYS_CLK_IN) disable iff (!NRST_IN)
		s_frozen ##1 s_still_set |-> $stable(q) && $stable(y)
	)
	else
		$error("state changed while clock enable was low");

	edge_only_a: assert property (
		@(posedge SYS_CLK_IN) disable iff (!NRST_IN)
		s_no_edge3 ##1 s_still_set |-> q == $past(q, 3)
	)
	else
		$error("stored word changed without a clock rise");

	clear_stored_a: assert property (
		@(posedge SYS_CLK_IN) disable iff (!NRST_IN)
		!CLEAR_N_IN && HAS_CTRL |-> q == Q_RESET
	)
	else
		$error("stored word not cleared while clear low");

	clear_output_a: assert property (
		@(posedge SYS_CLK_IN) disable iff (!NRST_IN)
		!clear_n && drive |-> Y_OUT == Y_RESET && Y_OE_OUT == {WIDTH{1'b1}}
	)
	else
		$error("driven bus does not show cleared value");

	clear_blocks_a: assert property (
		@(posedge SYS_CLK_IN) disable iff (!NRST_IN)
		CLK_EN_IN && clk_rise && !enable_n && !clear_n |=> q == Q_RESET
	)
	else
		$error("data entered storage while clear was low");

	clear_keeps_a: assert property (
		@(posedge SYS_CLK_IN) disable iff (!NRST_IN)
		!clear_n && $stable(OE_N_IN) |-> $stable(Y_OE_OUT)
	)
	else
		$error("clear disturbed output drive");

	multi_off_a: assert property (
		@(posedge SYS_CLK_IN) disable iff (!NRST_IN)
		HAS_MULTI_OE && OE_N_IN != `BIR_OE_ALL_ON |-> Y_OE_OUT == '0
	)
	else
		$error("bus driven while one drive enable was high");

	multi_on_a: assert property (
		@(posedge SYS_CLK_IN) disable iff (!NRST_IN)
		HAS_MULTI_OE && OE_N_IN == `BIR_OE_ALL_ON |-> &Y_OE_OUT
	)
	else
		$error("bus not driven with all drive enables low");

	single_off_a: assert property (
		@(posedge SYS_CLK_IN) disable iff (!NRST_IN)
		!HAS_MULTI_OE && OE_N_IN[0] |-> Y_OE_OUT == '0
	)
	else
		$error("bus driven while output control high");

	single_on_a: assert property (
		@(posedge SYS_CLK_IN) disable iff (!NRST_IN)
		!HAS_MULTI_OE && !OE_N_IN[0] |-> &Y_OE_OUT
	)
	else
		$error("bus not driven while output control low");

	polarity_a: assert property (
		@(posedge SYS_CLK_IN) disable iff (!NRST_IN)
		Y_OUT == (INV ? ~q : q)
	)
	else
		$error("bus value does not match stored word polarity");

	load_to_bus_a: assert property (
		@(posedge SYS_CLK_IN) disable iff (!NRST_IN)
		s_load ##1 (clear_n && drive) |->
			Y_OUT == (INV ? ~$past(D_IN) : $past(D_IN))
	)
	else
		$error("captured data not shown on bus");

	ten_bit_a: assert property (
		@(posedge SYS_CLK_IN) disable iff (!NRST_IN)
		!HAS_CTRL && CLK_EN_IN && clk_rise |=> q == $past(D_IN)
	)
	else
		$error("ten-bit variant ignored a clock rise");

	single_load_a: assert property (
		@(posedge SYS_CLK_IN) disable iff (!NRST_IN)
		s_load ##1 (CLK_EN_IN && REG_CLOCK_IN && clear_n) |-> !clk_rise
	)
	else
		$error("one register clock high counted twice");

	bus_hold_a: assert property (
		@(posedge SYS_CLK_IN) disable iff (!NRST_IN)
		s_idle ##1 s_still_set |-> $stable(Y_OUT)
	)
	else
		$error("bus word changed without a capture");

	detect_follow_a: assert property (
		@(posedge SYS_CLK_IN) disable iff (!NRST_IN)
		CLK_EN_IN |=> reg_clock_prev == $past(REG_CLOCK_IN)
	)
	else
		$error("register clock sample not kept for edge test");

	freeze_detect_a: assert property (
		@(posedge SYS_CLK_IN) disable iff (!NRST_IN)
		!CLK_EN_IN |=> $stable(reg_clock_prev)
	)
	else
		$error("edge detector moved while clock enable was low");

	wide_no_clear_a: assert property (
		@(posedge SYS_CLK_IN) disable iff (!NRST_IN)
		!HAS_CTRL && !CLEAR_N_IN && CLK_EN_IN && clk_rise |=>
			q == $past(D_IN)
	)
	else
		$error("ten-bit variant obeyed a clear input");

	clear_frozen_a: assert property (
		@(posedge SYS_CLK_IN) disable iff (!NRST_IN)
		HAS_CTRL && !CLEAR_N_IN && !CLK_EN_IN |->
			q == Q_RESET && Y_OUT == Y_RESET
	)
	else
		$error("clear ignored while clock enable was low");
endmodule

// ---- sim/bir_src.sv ----
`timescale 1ns/10ps
module bir_src
(
	input wire logic clk_in,
	input wire logic go_in,
	input wire logic [7:0] word_in,
	output logic reg_clock_out,
	output logic [7:0] d_out
);
	logic [1:0] step;
	initial
	begin
		step = 2'h0;
		reg_clock_out = 1'b0;
		d_out = 8'h00;
	end
	// Low, high, low: one clean rising edge per word
	always @(posedge clk_in)
	begin
		if (go_in)
		begin
			step <= 2'h1;
			d_out <= word_in;
			reg_clock_out <= 1'b0;
		end
		else if (step == 2'h1)
		begin
			step <= 2'h2;
			reg_clock_out <= 1'b1;
		end
		else if (step == 2'h2)
		begin
			step <= 2'h0;
			reg_clock_out <= 1'b0;
			// Hold over: stale data must not be captured
			d_out <= ~d_out;
		end
	end
endmodule

// ---- sim/testbench.sv ----
`timescale 1ns/10ps
`include "bir_defs.svh"
module testbench
	import bir_pkg::*;
;
	logic sys_clk = 1'b0;
	logic nrst = 1'b0;
	logic clk_en = 1'b1;
	logic enable_n = 1'b0;
	logic clear_n = 1'b1;
	logic [2:0] oe_n = 3'h0;
	logic go = 1'b0;
	logic [7:0] word = 8'h00;
	logic reg_clock;
	logic [7:0] d;
	logic [7:0] y;
	logic [7:0] y_oe;
	logic [8:0] y9;
	logic [8:0] y9_oe;
	logic [9:0] y10;
	logic [9:0] y10_oe;
	int errors = 0;
	int total_checks = 0;
	always #5 sys_clk = ~sys_clk;
	bir_src src (.clk_in(sys_clk), .go_in(go), .word_in(word),
		.reg_clock_out(reg_clock), .d_out(d));
	bir_top #(.WIDTH(8), .POLARITY(BIR_POL_TRUE)) dut (
		.SYS_CLK_IN(sys_clk), .NRST_IN(nrst), .CLK_EN_IN(clk_en),
		.REG_CLOCK_IN(reg_clock), .ENABLE_N_IN(enable_n),
		.CLEAR_N_IN(clear_n), .OE_N_IN(oe_n), .D_IN(d),
		.Y_OUT(y), .Y_OE_OUT(y_oe));
	// Nine-bit inverting copy; top data bit stands in for parity
	bir_top #(.WIDTH(9), .POLARITY(BIR_POL_INV)) dut_par (
		.SYS_CLK_IN(sys_clk), .NRST_IN(nrst), .CLK_EN_IN(clk_en),
		.REG_CLOCK_IN(reg_clock), .ENABLE_N_IN(enable_n),
		.CLEAR_N_IN(clear_n), .OE_N_IN(oe_n), .D_IN({d[0], d}),
		.Y_OUT(y9), .Y_OE_OUT(y9_oe));
	// Ten-bit copy sees the same enable and clear, and must ignore them
	bir_top #(.WIDTH(10), .POLARITY(BIR_POL_TRUE)) dut_wide (
		.SYS_CLK_IN(sys_clk), .NRST_IN(nrst), .CLK_EN_IN(clk_en),
		.REG_CLOCK_IN(reg_clock), .ENABLE_N_IN(enable_n),
		.CLEAR_N_IN(clear_n), .OE_N_IN(oe_n), .D_IN({d[1:0], d}),
		.Y_OUT(y10), .Y_OE_OUT(y10_oe));
	task automatic chk(input logic [9:0] got, input logic [9:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			errors++;
			$display("BAD at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// Stored word w in both narrow parts, wide_w in the ten-bit part
	task automatic chk_all(input logic [7:0] w, input logic [7:0] wide_w);
		logic [8:0] inv9;
		inv9 = ~{w[0], w};
		chk(10'(y), 10'(w));
		chk(10'(y9), 10'(inv9));
		chk(y10, {wide_w[1:0], wide_w});
	endtask
	task automatic load(input logic [7:0] w);
		@(posedge sys_clk);
		word <= w;
		go <= 1'b1;
		@(posedge sys_clk);
		go <= 1'b0;
		repeat (2) @(posedge sys_clk);
		#1;
	endtask
	task automatic t_load();
		load(8'ha5);
		chk_all(8'ha5, 8'ha5);
		chk(10'(y_oe), 10'h0ff);
		chk(10'(y9_oe), 10'h1ff);
		chk(y10_oe, 10'h3ff);
		load(8'h5a);
		chk_all(8'h5a, 8'h5a);
	endtask
	task automatic t_hold();
		@(posedge sys_clk);
		enable_n <= 1'b1;
		load(8'h3c);
		chk_all(8'h5a, 8'h3c);
		@(posedge sys_clk);
		enable_n <= 1'b0;
	endtask
	task automatic t_clear();
		@(posedge sys_clk);
		clear_n <= 1'b0;
		#1;
		chk_all(8'h00, 8'h3c);
		load(8'hff);
		chk_all(8'h00, 8'hff);
		chk(10'(y_oe), 10'h0ff);
		chk(10'(y9_oe), 10'h1ff);
		@(posedge sys_clk);
		clear_n <= 1'b1;
		#1;
		chk_all(8'h00, 8'hff);
		load(8'h81);
		chk_all(8'h81, 8'h81);
	endtask
	task automatic t_oe();
		logic [9:0] exp8;
		logic [9:0] exp_one;
		for (int i = 0; i < 8; i++)
		begin
			@(posedge sys_clk);
			oe_n <= i[2:0];
			exp8 = (i[2:0] == `BIR_OE_ALL_ON) ? 10'h0ff : 10'h000;
			exp_one = i[0] ? 10'h000 : 10'h3ff;
			#1;
			chk(10'(y_oe), exp8);
			chk(10'(y9_oe), exp_one & 10'h1ff);
			chk(y10_oe, exp_one);
			chk(10'(y), 10'h081);
		end
		@(posedge sys_clk);
		oe_n <= 3'h0;
	endtask
	// A rise seen while frozen must not be replayed once thawed
	task automatic t_freeze();
		@(posedge sys_clk);
		clk_en <= 1'b0;
		load(8'hc3);
		chk_all(8'h81, 8'h81);
		@(posedge sys_clk);
		clear_n <= 1'b0;
		#1;
		chk_all(8'h00, 8'h81);
		@(posedge sys_clk);
		clear_n <= 1'b1;
		clk_en <= 1'b1;
		repeat (2) @(posedge sys_clk);
		#1;
		chk_all(8'h00, 8'h81);
	endtask
	task automatic t_reset();
		load(8'h66);
		chk_all(8'h66, 8'h66);
		@(posedge sys_clk);
		nrst <= 1'b0;
		#1;
		chk_all(8'h00, 8'h00);
		repeat (2) @(posedge sys_clk);
		nrst <= 1'b1;
		load(8'h99);
		chk_all(8'h99, 8'h99);
	endtask
	task automatic close_out();
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial
	begin
		repeat (10) @(posedge sys_clk);
		nrst <= 1'b1;
		#1;
		chk_all(8'h00, 8'h00);
		t_load();
		t_hold();
		t_clear();
		t_oe();
		t_freeze();
		t_reset();
		close_out();
	end
endmodule
